//--- src/power_index_limit_table_shaper.sv
// Function
// RQ1 - eight-entry power table plus a three-bit limit selecting the steady entry
// RQ2 - at frame start and end, step indices zero to limit and back
// RQ3 - host disables ramping by limit zero and power in entry zero
// RQ4 - on-off keying uses entry zero for zero, entry one for one
// RQ5 - host avoids writing table values 0x61 through 0x6f
// RQ6 - after reset entry zero holds 0xc6
// RQ7 - only burst writes reach entries beyond zero; single writes hit zero
// RQ8 - sleep keeps entry zero and clears all other entries
// RQ9 - amplitude keying counter rises on one, falls on zero
// RQ10 - counter steps eight times per symbol
// RQ11 - counter saturates at limit and at zero
// RQ12 - counter value indexes the power table directly
// RQ13 - host sets limit to seven for amplitude keying
// RQ14 - host loads only 0x00 and 0x30..0x3f into shaping entries
// RQ15 - index held zero when idle; ramp steps eight per symbol
`timescale 1ns/10ps
module power_index_limit_table_shaper (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // register port
  input  wire pa_shaper_pkg::bus_req_s bus_req,
  output logic [31:0]                  rdata,
  // modulator
  input  wire logic                    tx_symbol,
  // power amplifier
  output logic [7:0]                   pa_setting,
  output logic [2:0]                   pa_index
);
  import pa_shaper_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]  table_r [TABLE_DEPTH];
  logic [2:0]  ptr_r;
  logic [2:0]  limit_r;
  mod_e        mod_r;
  logic        tx_en_r;
  logic        sleep_r;
  logic [15:0] div_r;
  logic [15:0] tick_cnt_r;
  logic        tick_r;
  logic [2:0]  shape_r;
  logic [2:0]  shape_nxt;
  logic [7:0]  setting_r;
  logic [2:0]  index_r;
  logic [31:0] rdata_r;

  wire logic   wr_table = bus_req.wr && (bus_req.addr == ADDR_TABLE);

  // ------------------------------------------------------------
  // power table
  // ------------------------------------------------------------
  // RQ6 RQ7 RQ8 table write rules
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < TABLE_DEPTH; i++) begin
        table_r[i] <= (i == 0) ? TABLE0_RESET : TABLE_CLEAR;
      end
    end else if (sleep_r) begin
      for (int i = 1; i < TABLE_DEPTH; i++) begin
        table_r[i] <= TABLE_CLEAR;
      end
    end else if (wr_table) begin
      if (bus_req.burst) begin
        table_r[ptr_r] <= bus_req.wdata[7:0];
      end else begin
        table_r[IDX_ZERO] <= bus_req.wdata[7:0];
      end
    end
  end

  // burst pointer: starts at zero, advances on each burst table access
  // RQ7 burst pointer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_r <= IDX_ZERO;
    end else if (bus_req.wr && bus_req.addr == ADDR_TABLE_PTR) begin
      ptr_r <= bus_req.wdata[2:0];
    end else if ((wr_table || (bus_req.rd && bus_req.addr == ADDR_TABLE)) && bus_req.burst) begin
      ptr_r <= ptr_r + IDX_ONE;
    end else if (!bus_req.burst && (bus_req.wr || bus_req.rd) && bus_req.addr == ADDR_TABLE) begin
      ptr_r <= IDX_ZERO;
    end
  end

  // ------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------
  // RQ1 limit field
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      limit_r <= IDX_ZERO;
    end else if (bus_req.wr && bus_req.addr == ADDR_FRONT_END) begin
      limit_r <= bus_req.wdata[LIMIT_LSB +: IDX_W];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mod_r   <= MOD_FSK;
      tx_en_r <= 1'b0;
      sleep_r <= 1'b0;
      div_r   <= DIV_RESET;
    end else if (bus_req.wr && bus_req.addr == ADDR_CONTROL) begin
      case (bus_req.wdata[CTRL_MOD_LSB +: 2])
        2'h1:    mod_r <= MOD_OOK;
        2'h2:    mod_r <= MOD_ASK;
        default: mod_r <= MOD_FSK;
      endcase
      tx_en_r <= bus_req.wdata[CTRL_TX_BIT];
      sleep_r <= bus_req.wdata[CTRL_SLEEP_BIT];
      div_r   <= bus_req.wdata[CTRL_DIV_LSB +: 16];
    end
  end

  // ------------------------------------------------------------
  // step tick at eight per symbol
  // ------------------------------------------------------------
  // RQ10 step rate divider
  always_ff @(posedge clk) begin
    if (!reset_n || !tx_en_r) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r >= div_r) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r     <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // shaping and ramp counter
  // ------------------------------------------------------------
  always_comb begin
    shape_nxt = shape_r;
    case (mod_r)
      // RQ9 RQ11 ask up down
      MOD_ASK: begin
        if (tx_symbol && shape_r < limit_r) begin
          shape_nxt = shape_r + IDX_ONE;
        end else if (!tx_symbol && shape_r != IDX_ZERO) begin
          shape_nxt = shape_r - IDX_ONE;
        end
      end
      default: begin
        // RQ2 RQ15 ramp up
        if (shape_r < limit_r) begin
          shape_nxt = shape_r + IDX_ONE;
        end else if (shape_r > limit_r) begin
          shape_nxt = limit_r;
        end
      end
    endcase
  end

  // ramp down: when tx ends, step back to zero at tick rate
  logic ramp_down_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ramp_down_r <= 1'b0;
    end else begin
      ramp_down_r <= !tx_en_r && (shape_r != IDX_ZERO);
    end
  end

  logic [15:0] down_cnt_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shape_r    <= IDX_ZERO;
      down_cnt_r <= 16'h0000;
    end else if (!tx_en_r) begin
      // RQ2 RQ15 ramp down
      if (shape_r == IDX_ZERO) begin
        down_cnt_r <= 16'h0000;
      end else if (down_cnt_r >= div_r) begin
        down_cnt_r <= 16'h0000;
        shape_r    <= shape_r - IDX_ONE;
      end else begin
        down_cnt_r <= down_cnt_r + 16'h0001;
      end
    end else begin
      // clear the leftover so a later ramp-down starts with a full step
      down_cnt_r <= 16'h0000;
      if (tick_r) begin
        shape_r <= shape_nxt;
      end
    end
  end

  // ------------------------------------------------------------
  // table lookup toward the amplifier
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      index_r   <= IDX_ZERO;
      setting_r <= TABLE_CLEAR;
    end else if (mod_r == MOD_OOK && tx_en_r && shape_r == limit_r) begin
      // RQ4 ook entry select
      index_r   <= tx_symbol ? IDX_ONE : IDX_ZERO;
      setting_r <= tx_symbol ? table_r[IDX_ONE] : table_r[IDX_ZERO];
    end else begin
      // RQ12 RQ1 counter indexes table
      index_r   <= shape_r;
      setting_r <= table_r[shape_r];
    end
  end

  assign pa_index   = index_r;
  assign pa_setting = setting_r;

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_TABLE:     rdata_r <= {24'h00_0000, bus_req.burst ? table_r[ptr_r] : table_r[IDX_ZERO]};
        ADDR_FRONT_END: rdata_r <= {29'h0000_0000, limit_r};
        ADDR_CONTROL:   rdata_r <= {8'h00, div_r, 4'h0, sleep_r, tx_en_r, mod_r};
        ADDR_STATUS:    rdata_r <= {25'h000_0000, ramp_down_r, shape_r, index_r};
        ADDR_TABLE_PTR: rdata_r <= {29'h0000_0000, ptr_r};
        default:        rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // RQ11 saturation
  sat_limit_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ11
    (mod_r == MOD_ASK && tx_en_r && $past(tx_en_r))
    |-> (shape_r <= limit_r || $past(shape_r) > limit_r))
    else $error("shaping counter passed limit");

  // RQ9 direction up
  ask_up_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ9
    (mod_r == MOD_ASK && tx_en_r && tick_r && tx_symbol && shape_r < limit_r)
    |=> shape_r == $past(shape_r) + IDX_ONE)
    else $error("ask counter failed to rise");

  // RQ9 direction down
  ask_down_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ9
    (mod_r == MOD_ASK && tx_en_r && tick_r && !tx_symbol && shape_r != IDX_ZERO && $stable(mod_r))
    |=> shape_r == $past(shape_r) - IDX_ONE)
    else $error("ask counter failed to fall");

  // RQ10 no step without tick
  step_rate_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ10
    (tx_en_r && !tick_r)
    |=> $stable(shape_r) || !tx_en_r)
    else $error("counter moved without tick");

  // RQ10 tick when count due
  tick_due_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ10
    (tx_en_r && tick_cnt_r >= div_r)
    |=> tick_r)
    else $error("step tick missed");

  // RQ12 index follows counter
  index_map_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ12
    (mod_r != MOD_OOK)
    |=> pa_index == $past(shape_r))
    else $error("index not counter");

  // RQ12 setting from table
  table_lookup_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ12
    (mod_r != MOD_OOK)
    |=> pa_setting == $past(table_r[shape_r]))
    else $error("setting not table entry");

  // RQ2 ramp up per tick
  ramp_up_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
    (mod_r != MOD_ASK && tx_en_r && tick_r && shape_r < limit_r)
    |=> shape_r == $past(shape_r) + IDX_ONE)
    else $error("ramp failed to rise");

  // RQ2 ramp down after transmit
  ramp_fall_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
    (!tx_en_r && shape_r != IDX_ZERO && down_cnt_r >= div_r)
    |=> shape_r == $past(shape_r) - IDX_ONE)
    else $error("ramp failed to fall");

  // RQ1 steady entry at limit
  steady_entry_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ1
    (mod_r != MOD_ASK && tx_en_r && shape_r == limit_r)
    |=> shape_r == $past(limit_r))
    else $error("steady index left limit");

  // RQ6 reset value
  reset_val_a: assert property (@(posedge clk) // RQ6
    !reset_n
    |=> table_r[IDX_ZERO] == TABLE0_RESET)
    else $error("entry zero reset wrong");

  // RQ7 single write lands in entry zero
  single_wr_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
    (wr_table && !bus_req.burst && !sleep_r)
    |=> table_r[IDX_ZERO] == $past(bus_req.wdata[7:0]))
    else $error("single write missed entry zero");

  // RQ7 single write spares entry one
  single_keep_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
    (wr_table && !bus_req.burst && !sleep_r)
    |=> table_r[IDX_ONE] == $past(table_r[IDX_ONE]))
    else $error("single write reached entry one");

  // RQ7 burst write lands at pointer
  burst_write_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ7
    (wr_table && bus_req.burst && !sleep_r)
    |=> table_r[$past(ptr_r)] == $past(bus_req.wdata[7:0]))
    else $error("burst write missed pointer entry");

  // RQ8 sleep clears entries one and seven
  sleep_clr_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ8
    sleep_r
    |=> table_r[7] == TABLE_CLEAR && table_r[IDX_ONE] == TABLE_CLEAR)
    else $error("sleep kept upper entries");

  // RQ8 sleep keeps entry zero
  sleep_keep_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ8
    sleep_r
    |=> table_r[IDX_ZERO] == $past(table_r[IDX_ZERO]))
    else $error("sleep changed entry zero");

  // RQ4 ook selection
  ook_sel_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
    (mod_r == MOD_OOK && tx_en_r && shape_r == limit_r)
    |=> pa_index == {2'h0, $past(tx_symbol)})
    else $error("ook entry wrong");

  // RQ4 ook power level
  ook_level_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
    (mod_r == MOD_OOK && tx_en_r && shape_r == limit_r)
    |=> pa_setting == ($past(tx_symbol) ? $past(table_r[IDX_ONE]) : $past(table_r[IDX_ZERO])))
    else $error("ook level wrong");

  // RQ15 idle counter stays zero
  idle_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ15
    (!tx_en_r && shape_r == IDX_ZERO)
    |=> shape_r == IDX_ZERO)
    else $error("idle counter moved");

  // RQ15 idle index zero
  idle_index_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ15
    (!tx_en_r && shape_r == IDX_ZERO)
    |=> pa_index == IDX_ZERO)
    else $error("idle index not zero");

endmodule : power_index_limit_table_shaper

//--- src/pa_shaper_pkg.sv
package pa_shaper_pkg;

  // ------------------------------------------------------------
  // register map (word addresses on the plain port)
  // ------------------------------------------------------------
  localparam int            ADDR_W            = 4;
  localparam logic [3:0]    ADDR_TABLE        = 4'h0;
  localparam logic [3:0]    ADDR_FRONT_END    = 4'h1;
  localparam logic [3:0]    ADDR_CONTROL      = 4'h2;
  localparam logic [3:0]    ADDR_STATUS       = 4'h3;
  localparam logic [3:0]    ADDR_TABLE_PTR    = 4'h4;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int            TABLE_DEPTH       = 8;
  localparam int            IDX_W             = 3;
  localparam logic [7:0]    TABLE0_RESET      = 8'hc6;
  localparam logic [7:0]    TABLE_CLEAR       = 8'h00;
  localparam logic [2:0]    IDX_ZERO          = 3'h0;
  localparam logic [2:0]    IDX_ONE           = 3'h1;
  localparam int            LIMIT_LSB         = 0;
  localparam int            CTRL_MOD_LSB      = 0;
  localparam int            CTRL_TX_BIT       = 2;
  localparam int            CTRL_SLEEP_BIT    = 3;
  localparam int            CTRL_DIV_LSB      = 8;
  localparam logic [15:0]   DIV_RESET         = 16'h0063;
  localparam logic [2:0]    STEPS_PER_SYMBOL  = 3'h7;

  typedef enum logic [1:0] {
    MOD_FSK,
    MOD_OOK,
    MOD_ASK
  } mod_e;

  // register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        burst;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } bus_req_s;

endpackage : pa_shaper_pkg

//--- bench/host_model.sv
`timescale 1ns/10ps
module host_model (
  // clock
  input  wire logic                clk,
  // register port
  output pa_shaper_pkg::bus_req_s  bus_req,
  input  wire logic [31:0]         rdata
);
  import pa_shaper_pkg::*;

  initial begin
    bus_req = '0;
  end

  // ----
  // bus cycles, two clocks each
  // ----
  // burst flag chosen
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic b);
    bus_req <= '{wr: 1'b1, rd: 1'b0, burst: b, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask : bus_wr

  // data stands one cycle after the strobe is taken
  task automatic bus_rd(input logic [3:0] a, input logic b, output logic [31:0] d);
    bus_req <= '{wr: 1'b0, rd: 1'b1, burst: b, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
    d = rdata;
  endtask : bus_rd
endmodule : host_model

//--- bench/tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import pa_shaper_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        tx_symbol;
  bus_req_s    bus_req;
  logic [31:0] rdata;
  logic [7:0]  pa_setting;
  logic [2:0]  pa_index;
  logic [7:0]  tbl [8];
  logic [31:0] d;
  logic [2:0]  seq [$];
  int          gap [$];
  int          bad_count = 0;
  int          cmp_count = 0;

  host_model host_model_i (.clk(clk), .bus_req(bus_req), .rdata(rdata));
  power_index_limit_table_shaper power_index_limit_table_shaper_i (.clk(clk), .reset_n(reset_n),
    .bus_req(bus_req), .rdata(rdata), .tx_symbol(tx_symbol),
    .pa_setting(pa_setting), .pa_index(pa_index));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----
  // helpers
  // ----
  task automatic ctrl(input mod_e m, input logic tx, input logic sl);
    host_model_i.bus_wr(ADDR_CONTROL, {8'h00, 16'h0003, 4'h0, sl, tx, m}, 1'b0);
  endtask : ctrl

  // records each index change and the cycles since the previous one
  task automatic watch(input int n);
    logic [2:0] last;
    int         c;
    last = pa_index;
    c = 0;
    seq = {};
    gap = {};
    repeat (n) begin
      @(posedge clk);
      c++;
      if (pa_index !== last) begin
        seq.push_back(pa_index);
        gap.push_back(c);
        c = 0;
        last = pa_index;
        `CHK(pa_setting, tbl[pa_index])
      end
    end
  endtask : watch

  task automatic chk_seq(input logic [2:0] e [$]);
    `CHK(seq.size(), e.size())
    foreach (e[i]) `CHK(seq[i], e[i])
  endtask : chk_seq

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    `CHK(pa_setting, TABLE0_RESET)
    `CHK(pa_index, IDX_ZERO)
    host_model_i.bus_rd(ADDR_TABLE, 1'b0, d);
    `CHK(d[7:0], TABLE0_RESET)
    host_model_i.bus_rd(ADDR_FRONT_END, 1'b0, d);
    `CHK(d, 32'h0)
    host_model_i.bus_rd(ADDR_CONTROL, 1'b0, d);
    `CHK(d, {8'h00, DIV_RESET, 8'h00})
    host_model_i.bus_rd(ADDR_STATUS, 1'b0, d);
    `CHK(d, 32'h0)
    host_model_i.bus_rd(4'hf, 1'b0, d);
    `CHK(d, 32'h0)
  endtask : t_reset

  task automatic t_table;
    host_model_i.bus_wr(ADDR_TABLE_PTR, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      tbl[i] = 8'h30 + 8'(2 * i);
      host_model_i.bus_wr(ADDR_TABLE, {24'h0, tbl[i]}, 1'b1);
    end
    tbl[0] = 8'h3f;
    host_model_i.bus_wr(ADDR_TABLE, {24'h0, tbl[0]}, 1'b0);
    for (int i = 0; i < 8; i++) begin
      host_model_i.bus_rd(ADDR_TABLE, 1'b1, d);
      `CHK(d[7:0], tbl[i])
    end
    `CHK(pa_setting, tbl[0])
    // limit zero holds entry zero while sending
    ctrl(MOD_FSK, 1'b1, 1'b0);
    watch(20);
    `CHK(seq.size(), 0)
    `CHK(pa_setting, tbl[0])
    ctrl(MOD_FSK, 1'b0, 1'b0);
  endtask : t_table

  task automatic t_ramp;
    host_model_i.bus_wr(ADDR_FRONT_END, 32'h3, 1'b0);
    ctrl(MOD_FSK, 1'b1, 1'b0);
    watch(40);
    chk_seq('{3'h1, 3'h2, 3'h3});
    `CHK(pa_setting, tbl[3])
    host_model_i.bus_rd(ADDR_STATUS, 1'b0, d);
    `CHK(d, 32'h0000_001b)
    ctrl(MOD_FSK, 1'b0, 1'b0);
    host_model_i.bus_rd(ADDR_STATUS, 1'b0, d);
    `CHK(d, 32'h0000_005b)
    watch(40);
    chk_seq('{3'h2, 3'h1, 3'h0});
  endtask : t_ramp

  task automatic t_ask;
    host_model_i.bus_wr(ADDR_FRONT_END, 32'h7, 1'b0);
    tx_symbol <= 1'b1;
    ctrl(MOD_ASK, 1'b1, 1'b0);
    watch(60);
    chk_seq('{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7});
    for (int i = 1; i < 7; i++) `CHK(gap[i], 4)
    watch(20);
    `CHK(seq.size(), 0)
    tx_symbol <= 1'b0;
    watch(60);
    chk_seq('{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0});
    watch(20);
    `CHK(seq.size(), 0)
    ctrl(MOD_FSK, 1'b0, 1'b0);
  endtask : t_ask

  task automatic t_ook;
    host_model_i.bus_wr(ADDR_FRONT_END, 32'h1, 1'b0);
    ctrl(MOD_OOK, 1'b1, 1'b0);
    watch(20);
    `CHK(pa_setting, tbl[0])
    tx_symbol <= 1'b1;
    watch(8);
    `CHK(pa_setting, tbl[1])
    tx_symbol <= 1'b0;
    watch(8);
    `CHK(pa_setting, tbl[0])
    ctrl(MOD_FSK, 1'b0, 1'b0);
    watch(20);
  endtask : t_ook

  task automatic t_sleep;
    ctrl(MOD_FSK, 1'b0, 1'b1);
    // entry zero write refused while asleep
    host_model_i.bus_wr(ADDR_TABLE, 32'h0, 1'b0);
    host_model_i.bus_wr(ADDR_TABLE_PTR, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      host_model_i.bus_rd(ADDR_TABLE, 1'b1, d);
      `CHK(d[7:0], (i == 0) ? tbl[0] : TABLE_CLEAR)
    end
    ctrl(MOD_FSK, 1'b0, 1'b0);
  endtask : t_sleep

  // ----
  // run control
  // ----
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  initial begin
    reset_n <= 1'b0;
    tx_symbol <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_table();
    t_ramp();
    t_ask();
    t_ook();
    t_sleep();
    give_verdict();
  end

  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
endmodule : tb
